//--- suspend_wake_defines.svh
`ifndef SUSPEND_WAKE_DEFINES_SVH
`define SUSPEND_WAKE_DEFINES_SVH

// ----------------------------------------------------------------------
// System clock
// ----------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 20

// ----------------------------------------------------------------------
// Times in their own units
// ----------------------------------------------------------------------
`define T_STATUS_OUTPUT_A_FALL_NS 7
`define T_FILTER_TYP_NS 300
`define T_OUT_SUSPEND_NS 10
`define T_WRITE_LOCK_NS 5
`define T_INPUT_DISABLE_NS 340
`define T_WAKE_MIN_NS 4000
`define T_INPUT_ENABLE_MIN_NS 3700

// ----------------------------------------------------------------------
// Cycle counts derived from the times
// ----------------------------------------------------------------------
`define CYC_DOWN(ns) ((((ns) / `SYS_CLK_PERIOD_NS) < 1) ? 1 : \
  ((ns) / `SYS_CLK_PERIOD_NS))
`define CYC_UP(ns) (((ns) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define STATUS_OUTPUT_A_FALL_CYC `CYC_DOWN(`T_STATUS_OUTPUT_A_FALL_NS)
`define FILTER_CYC `CYC_DOWN(`T_FILTER_TYP_NS)
`define OUT_SUSPEND_CYC `CYC_DOWN(`T_OUT_SUSPEND_NS)
`define WRITE_LOCK_CYC `CYC_DOWN(`T_WRITE_LOCK_NS)
`define INPUT_DISABLE_CYC `CYC_DOWN(`T_INPUT_DISABLE_NS)
`define WAKE_CYC `CYC_UP(`T_WAKE_MIN_NS)
`define INPUT_ENABLE_CYC `CYC_UP(`T_INPUT_ENABLE_MIN_NS)

// ----------------------------------------------------------------------
// Release counts, widths, oscillator divider
// ----------------------------------------------------------------------
`define RELEASE_SHORT_CYC 1
`define RELEASE_LONG_CYC 512
`define RELEASE_CNT_W 10
`define SEQ_CNT_W 8
`define LOW_RUN_W 9
`define OSC_DIV_W 4
`define OSC_DIV_DEFAULT 3

`endif

//--- suspend_wake_pkg.sv
`include "suspend_wake_defines.svh"

package suspend_wake_pkg;

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STATUS_OUTPUT_A     = 3'b000,
    ST_FILTER    = 3'b001,
    ST_ENTER     = 3'b010,
    ST_SUSPENDED = 3'b011,
    ST_EXIT      = 3'b100,
    ST_RELEASE   = 3'b101
  } seq_state_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic glitch_filter_enable;
    logic wake_sequence_clock_select;
    logic write_release_cycle_count;
    logic output_release_cycle_count;
  } cfg_t;

  typedef struct packed {
    logic status_output_a;
    logic write_lock;
    logic outputs_suspended;
    logic inputs_disabled;
  } ctrl_t;

  // --------------------------------------------------------------------
  // Module state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic [`RELEASE_CNT_W-1:0] cnt;
    logic done;
  } rt_regs_t;

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic req_prev;
    seq_state_t st;
    logic [`SEQ_CNT_W-1:0] cnt;
    logic [`OSC_DIV_W-1:0] div_cnt;
    logic [`LOW_RUN_W-1:0] low_run;
    ctrl_t ctrl;
  } seq_regs_t;

endpackage

//--- release_timer.sv
`timescale 1ns/10ps
`include "suspend_wake_defines.svh"

module release_timer #(
  parameter logic [`RELEASE_CNT_W-1:0] SHORT_COUNT =
    `RELEASE_CNT_W'(`RELEASE_SHORT_CYC),
  parameter logic [`RELEASE_CNT_W-1:0] LONG_COUNT =
    `RELEASE_CNT_W'(`RELEASE_LONG_CYC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic tick,
  input wire logic long_sel,
  // Result
  output logic done
);

  suspend_wake_pkg::rt_regs_t r_reg;
  suspend_wake_pkg::rt_regs_t r_next;
  logic [`RELEASE_CNT_W-1:0] last;

  // Last count value for the chosen length
  assign last = (long_sel ? LONG_COUNT : SHORT_COUNT) -
    `RELEASE_CNT_W'(1);

  // Count ticks after start, pulse done at the end
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.busy = 1'b1;
      r_next.cnt = '0;
    end else if (r_reg.busy && tick) begin
      if (r_reg.cnt == last) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + `RELEASE_CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;

endmodule // release_timer

//--- suspend_wake_sequencer.sv
`timescale 1ns/10ps
`include "suspend_wake_defines.svh"

// Function
// [R01] Status_output_a falls one cycle after request rises
// [R02] Glitch filter delays entry response, except re-entry during exit
// [R03] Outputs take suspend behaviour after rise
// [R04] Writes to clocked storage locked promptly
// [R05] Inputs and interconnect disabled last, 340 ns
// [R06] Status_output_a rises at least 4 us after fall
// [R07] Inputs re-enabled at least 3.7 us after fall
// [R08] Write lock lifts 1 or 512 ticks later
// [R09] Outputs released 1 or 512 ticks later
// [R10] Stay suspended while request stays high
module suspend_wake_sequencer #(
  parameter int OSC_DIV = `OSC_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Suspend request pin, asynchronous
  input wire logic suspend_request,
  // Static configuration
  input suspend_wake_pkg::cfg_t cfg,
  // Sequencer outputs
  output suspend_wake_pkg::ctrl_t ctrl
);

  // --------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------
  localparam int FILT_C = `FILTER_CYC;
  localparam int DIS_C = `INPUT_DISABLE_CYC;
  localparam int WAKE_C = `WAKE_CYC;
  localparam int EN_C = `INPUT_ENABLE_CYC;
  localparam int AF_C = `STATUS_OUTPUT_A_FALL_CYC;
  localparam int OS_C = `OUT_SUSPEND_CYC;
  localparam int WL_C = `WRITE_LOCK_CYC;
  localparam int LATE_C = WAKE_C + DIS_C + 4;
  localparam logic [`SEQ_CNT_W-1:0] FILT_END = `SEQ_CNT_W'(FILT_C - 2);
  localparam logic [`SEQ_CNT_W-1:0] DIS_END = `SEQ_CNT_W'(DIS_C - 2);
  localparam logic [`SEQ_CNT_W-1:0] WAKE_END = `SEQ_CNT_W'(WAKE_C - 2);
  localparam logic [`SEQ_CNT_W-1:0] EN_END = `SEQ_CNT_W'(EN_C - 2);

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  suspend_wake_pkg::seq_regs_t r_reg;
  suspend_wake_pkg::seq_regs_t r_next;
  logic req;
  logic rise;
  logic osc_tick;
  logic rel_tick;
  logic start_rel;
  logic wr_done;
  logic out_done;

  assign req = r_reg.sync_b;
  assign rise = r_reg.sync_b & ~r_reg.req_prev;
  assign osc_tick = (r_reg.div_cnt == '0);
  assign rel_tick = cfg.wake_sequence_clock_select ? osc_tick : 1'b1;

  // Start of entry, through the filter or straight in
  function automatic suspend_wake_pkg::seq_regs_t begin_entry(
    input suspend_wake_pkg::seq_regs_t s, input logic filt);
    suspend_wake_pkg::seq_regs_t t;
    t = s;
    t.cnt = '0;
    if (filt) begin
      t.st = suspend_wake_pkg::ST_FILTER; // [R02]
    end else begin
      t.st = suspend_wake_pkg::ST_ENTER;
      t.ctrl.status_output_a = 1'b0; // [R01]
      t.ctrl.write_lock = 1'b1; // [R04]
      t.ctrl.outputs_suspended = 1'b1; // [R03]
    end
    return t;
  endfunction

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    start_rel = 1'b0;
    r_next.sync_a = suspend_request;
    r_next.sync_b = r_reg.sync_a;
    r_next.req_prev = r_reg.sync_b;
    if (r_reg.sync_b) begin
      r_next.low_run = '0;
    end else if (r_reg.low_run != '1) begin
      r_next.low_run = r_reg.low_run + `LOW_RUN_W'(1);
    end
    r_next.div_cnt = osc_tick ? `OSC_DIV_W'(OSC_DIV - 1) :
      r_reg.div_cnt - `OSC_DIV_W'(1);
    unique case (r_reg.st)
      suspend_wake_pkg::ST_STATUS_OUTPUT_A: begin
        if (rise) begin
          r_next = begin_entry(r_next, cfg.glitch_filter_enable);
        end
      end
      suspend_wake_pkg::ST_FILTER: begin
        if (!req) begin
          // Glitch: back where we were, restarting any release
          if (r_reg.ctrl.write_lock || r_reg.ctrl.outputs_suspended) begin
            r_next.st = suspend_wake_pkg::ST_RELEASE;
            start_rel = 1'b1;
          end else begin
            r_next.st = suspend_wake_pkg::ST_STATUS_OUTPUT_A;
          end
        end else if (r_reg.cnt == FILT_END) begin
          r_next = begin_entry(r_next, 1'b0); // [R02]
        end else begin
          r_next.cnt = r_reg.cnt + `SEQ_CNT_W'(1);
        end
      end
      suspend_wake_pkg::ST_ENTER: begin
        if (r_reg.cnt == DIS_END) begin
          r_next.st = suspend_wake_pkg::ST_SUSPENDED;
          r_next.ctrl.inputs_disabled = 1'b1; // [R05]
        end else begin
          r_next.cnt = r_reg.cnt + `SEQ_CNT_W'(1);
        end
      end
      suspend_wake_pkg::ST_SUSPENDED: begin
        // Hold everything until the request falls
        if (!req) begin // [R10]
          r_next.st = suspend_wake_pkg::ST_EXIT;
          r_next.cnt = '0;
        end
      end
      suspend_wake_pkg::ST_EXIT: begin
        if (req) begin
          // Request back before wake: suspend again
          r_next.st = suspend_wake_pkg::ST_ENTER; // [R10]
          r_next.cnt = '0;
        end else begin
          r_next.cnt = r_reg.cnt + `SEQ_CNT_W'(1);
          if (r_reg.cnt == EN_END) begin
            r_next.ctrl.inputs_disabled = 1'b0; // [R07]
          end
          if (r_reg.cnt == WAKE_END) begin
            r_next.ctrl.status_output_a = 1'b1; // [R06]
            r_next.st = suspend_wake_pkg::ST_RELEASE;
            start_rel = 1'b1;
          end
        end
      end
      suspend_wake_pkg::ST_RELEASE: begin
        if (rise) begin
          r_next = begin_entry(r_next, cfg.glitch_filter_enable);
        end else begin
          if (wr_done) begin
            r_next.ctrl.write_lock = 1'b0; // [R08]
          end
          if (out_done) begin
            r_next.ctrl.outputs_suspended = 1'b0; // [R09]
          end
          if (!r_next.ctrl.write_lock && !r_next.ctrl.outputs_suspended) begin
            r_next.st = suspend_wake_pkg::ST_STATUS_OUTPUT_A;
          end
        end
      end
      default: begin
        r_next.st = suspend_wake_pkg::ST_STATUS_OUTPUT_A;
      end
    endcase
  end

  // State register, status_output_a after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
      r_reg.ctrl.status_output_a <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ctrl = r_reg.ctrl;

  // --------------------------------------------------------------------
  // Release timers
  // --------------------------------------------------------------------
  release_timer u_write_release (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start_rel),
    .tick(rel_tick),
    .long_sel(cfg.write_release_cycle_count),
    .done(wr_done)
  );

  release_timer u_output_release (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start_rel),
    .tick(rel_tick),
    .long_sel(cfg.output_release_cycle_count),
    .done(out_done)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_status_output_a_fall;
    rise && !cfg.glitch_filter_enable && r_reg.st == suspend_wake_pkg::ST_STATUS_OUTPUT_A
      |-> ##AF_C !ctrl.status_output_a;
  endproperty
  a_status_output_a_fall: assert property (p_status_output_a_fall) // [R01]
    else $error("status_output_a did not fall after request");

  property p_filter_hold;
    rise && cfg.glitch_filter_enable && r_reg.st == suspend_wake_pkg::ST_STATUS_OUTPUT_A
      |=> ctrl.status_output_a [*8];
  endproperty
  a_filter_hold: assert property (p_filter_hold) // [R02]
    else $error("filtered entry responded too early");

  property p_filter_glitch;
    r_reg.st == suspend_wake_pkg::ST_FILTER && !req
      |=> ctrl.status_output_a && !ctrl.inputs_disabled;
  endproperty
  a_filter_glitch: assert property (p_filter_glitch) // [R02]
    else $error("glitch caused suspend entry");

  property p_out_suspend;
    rise && !cfg.glitch_filter_enable && r_reg.st == suspend_wake_pkg::ST_STATUS_OUTPUT_A
      |-> ##OS_C ctrl.outputs_suspended;
  endproperty
  a_out_suspend: assert property (p_out_suspend) // [R03]
    else $error("outputs not suspended in time");

  property p_write_lock;
    rise && !cfg.glitch_filter_enable && r_reg.st == suspend_wake_pkg::ST_STATUS_OUTPUT_A
      |-> ##WL_C (ctrl.write_lock && !ctrl.status_output_a);
  endproperty
  a_write_lock: assert property (p_write_lock) // [R04]
    else $error("write lock late");

  property p_input_disable;
    rise && !cfg.glitch_filter_enable && r_reg.st == suspend_wake_pkg::ST_STATUS_OUTPUT_A
      |-> ##(DIS_C - 1) !ctrl.inputs_disabled ##1 ctrl.inputs_disabled;
  endproperty
  a_input_disable: assert property (p_input_disable) // [R05]
    else $error("inputs not disabled at 340 ns");

  property p_wake_min;
    $rose(ctrl.status_output_a) |-> r_reg.low_run >= `LOW_RUN_W'(WAKE_C);
  endproperty
  a_wake_min: assert property (p_wake_min) // [R06]
    else $error("status_output_a rose too early");

  property p_wake_late;
    r_reg.low_run == `LOW_RUN_W'(LATE_C) |-> ctrl.status_output_a;
  endproperty
  a_wake_late: assert property (p_wake_late) // [R06]
    else $error("status_output_a did not rise");

  property p_enable;
    $fell(ctrl.inputs_disabled) |-> r_reg.low_run >= `LOW_RUN_W'(EN_C);
  endproperty
  a_enable: assert property (p_enable) // [R07]
    else $error("inputs re-enabled too early");

  property p_write_release;
    $rose(ctrl.status_output_a) && !cfg.wake_sequence_clock_select &&
      !cfg.write_release_cycle_count
      |-> ctrl.write_lock ##2 (!ctrl.write_lock || $past(req) || $past(req, 2));
  endproperty
  a_write_release: assert property (p_write_release) // [R08]
    else $error("write lock not lifted after one cycle");

  property p_output_release;
    $rose(ctrl.status_output_a) && !cfg.wake_sequence_clock_select &&
      !cfg.output_release_cycle_count
      |-> ctrl.outputs_suspended ##2
        (!ctrl.outputs_suspended || $past(req) || $past(req, 2));
  endproperty
  a_output_release: assert property (p_output_release) // [R09]
    else $error("outputs not released after one cycle");

  property p_hold;
    r_reg.st == suspend_wake_pkg::ST_SUSPENDED && req
      |=> r_reg.st == suspend_wake_pkg::ST_SUSPENDED && ctrl.write_lock &&
        ctrl.inputs_disabled && !ctrl.status_output_a;
  endproperty
  a_hold: assert property (p_hold) // [R10]
    else $error("left suspend while request high");

  c_suspended: cover property (
    $rose(r_reg.st == suspend_wake_pkg::ST_SUSPENDED));
  c_wake: cover property ($rose(ctrl.status_output_a));
  c_glitch: cover property (
    r_reg.st == suspend_wake_pkg::ST_FILTER && !req);
  c_long_release: cover property (
    cfg.write_release_cycle_count && $fell(ctrl.write_lock));

endmodule // suspend_wake_sequencer

//--- suspend_controller.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// System controller driving the suspend request pin
// ----------------------------------------------------------------------
module suspend_controller (
  // Clock
  input wire logic clk_sys,
  // Command from the bench
  input wire logic want_suspend,
  // Request pin
  output logic suspend_request
);

  // Request level held for as long as suspend is wanted
  always @(posedge clk_sys) begin
    suspend_request <= want_suspend;
  end

endmodule // suspend_controller

//--- test_suspend_wake_sequencer.sv
`timescale 1ns/10ps

module test_suspend_wake_sequencer;

  // --------------------------------------------------------------------
  // Signals and bookkeeping
  // --------------------------------------------------------------------
  localparam int OSC = 3;
  typedef struct {
    suspend_wake_pkg::ctrl_t v;
    int lo;
    int hi;
  } note_t;
  logic clk_sys;
  logic rstn;
  logic want;
  logic suspend_request;
  suspend_wake_pkg::cfg_t cfg;
  suspend_wake_pkg::ctrl_t ctrl;
  suspend_wake_pkg::ctrl_t prev;
  suspend_wake_pkg::cfg_t cfg_list [6] = '{4'h0, 4'h8, 4'h2, 4'h1, 4'h4,
    4'hB};
  note_t notes [$];
  int cyc = 0;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] lfsr_state;

  suspend_wake_sequencer #(.OSC_DIV(OSC)) u_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .suspend_request(suspend_request),
    .cfg(cfg),
    .ctrl(ctrl)
  );

  suspend_controller u_partner (
    .clk_sys(clk_sys),
    .want_suspend(want),
    .suspend_request(suspend_request)
  );

  // Clock and cycle count
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic fail(input string msg);
    bad_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic note(input suspend_wake_pkg::ctrl_t v, input int lo,
    input int hi);
    note_t n;
    n.v = v;
    n.lo = lo;
    n.hi = hi;
    notes.push_back(n);
  endtask

  task automatic cmp_ctrl(input suspend_wake_pkg::ctrl_t got,
    input note_t n);
    cmp_count++;
    if (got !== n.v || cyc < n.lo || cyc > n.hi)
      fail("control step has wrong value or time");
  endtask

  task automatic cmp_idle();
    cmp_count++;
    if (notes.size() != 0) fail("expected control step missing");
    notes.delete();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Filtered pulse too short to enter suspend
  task automatic glitch();
    cfg = 4'h8;
    cycles(2);
    want = 1'b1;
    cycles(8);
    want = 1'b0;
    cycles(40);
    cmp_idle();
  endtask

  // Full suspend and wake, optional re-entry during exit
  task automatic run(input suspend_wake_pkg::cfg_t c, input int hold,
    input bit again);
    int p;
    int q;
    int a;
    int m;
    int nw;
    int no;
    int lst;
    cfg = c;
    cycles(2);
    p = cyc + (c.glitch_filter_enable ? 14 : 0);
    want = 1'b1;
    note(4'h6, p + 3, p + 6);
    note(4'h7, p + 19, p + 22);
    cycles(hold);
    q = cyc;
    want = 1'b0;
    note(4'h6, q + 186, q + 190);
    if (again) begin
      cycles(192);
      q = cyc;
      want = 1'b1;
      note(4'h7, q + 19, q + 23);
      cycles(40);
      q = cyc;
      want = 1'b0;
      note(4'h6, q + 186, q + 190);
    end
    a = q + 203;
    note(4'hE, a - 2, a + 2);
    m = c.wake_sequence_clock_select ? OSC : 1;
    nw = c.write_release_cycle_count ? 512 : 1;
    no = c.output_release_cycle_count ? 512 : 1;
    if (nw == no) begin
      note(4'h8, a - 2 + nw * m, a + 3 + nw * m + m);
    end else if (nw < no) begin
      note(4'hA, a - 2 + nw * m, a + 3 + nw * m + m);
      note(4'h8, a - 2 + no * m, a + 3 + no * m + m);
    end else begin
      note(4'hC, a - 2 + no * m, a + 3 + no * m + m);
      note(4'h8, a - 2 + nw * m, a + 3 + nw * m + m);
    end
    lst = (nw > no) ? nw : no;
    cycles(a + lst * m + m + 10 - cyc);
    cmp_idle();
  endtask

  // Result watcher
  always @(negedge clk_sys) begin
    if (rstn === 1'b1 && ctrl !== prev) begin
      if (notes.size() == 0) begin
        fail("unexpected control step");
      end else begin
        cmp_ctrl(ctrl, notes.pop_front());
      end
      prev = ctrl;
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    want = 1'b0;
    cfg = 4'h0;
    prev = 4'h8;
    lfsr_state = 8'h1C;
    cycles(10);
    rstn = 1'b1;
    cycles(2);
    cmp_count++;
    if (ctrl !== 4'h8) fail("control value after reset");
    glitch();
    foreach (cfg_list[i]) begin
      lfsr_state = lfsr_step(lfsr_state);
      run(cfg_list[i], 40 + int'(lfsr_state[5:0]), i == 0);
    end
    end_of_test();
  end

  // Watchdog
  initial begin
    #(20 * 30000);
    fail("watchdog expired");
    end_of_test();
  end

endmodule // test_suspend_wake_sequencer
